// ===== logic/rdm_resp_consts.vh
// constants for the response type selector
`ifndef RDM_RESP_CONSTS_VH
`define RDM_RESP_CONSTS_VH
`define RT_ACK          8'h00
`define RT_ACK_TIMER    8'h01
`define RT_NACK_REASON  8'h02
`define RT_ACK_OVERFLOW 8'h03
`define CC_DISC         8'h10
`define CC_DISC_RESP    8'h11
`define CC_GET          8'h20
`define CC_GET_RESP     8'h21
`define CC_SET          8'h30
`define CC_SET_RESP     8'h31
`define PID_QUEUED      16'h0020
`define TIMER_PDL       8'h02
`define MAX_PDL         8'hE7
`define QDEPTH_LOG2     2
`endif

// ===== logic/queue_mem.v
// small queue memory for deferred replies, registered read data
`timescale 1ns/1ps
`default_nettype none
module queue_mem (
  input  wire        ref_clk,
  input  wire        wr_en,
  input  wire [1:0]  wr_addr,
  input  wire [39:0] wr_data,
  input  wire [1:0]  rd_addr,
  output reg  [39:0] rd_data
);
  reg [39:0] mem [0:3];
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // queue_mem
`default_nettype wire

// ===== logic/rdm_response_type_selector.v
// response type selection, overflow tracking and deferred reply queue
`timescale 1ns/1ps
`default_nettype none
`include "rdm_resp_consts.vh"
module rdm_response_type_selector (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_class,
  input  wire [15:0] cmd_pid,
  input  wire [15:0] cmd_sub_device,
  input  wire        cmd_checksum_ok,
  input  wire        cmd_broadcast,
  input  wire [15:0] data_total_len,
  input  wire        data_late,
  input  wire [15:0] est_time_100ms,
  input  wire        nack_req,
  input  wire        deferred_ready,
  input  wire [7:0]  deferred_class,
  input  wire [15:0] deferred_pid,
  output reg         resp_valid,
  output reg  [7:0]  resp_type,
  output reg  [7:0]  resp_class,
  output reg  [15:0] resp_pid,
  output reg  [15:0] resp_sub_device,
  output reg  [7:0]  resp_pdl,
  output reg  [15:0] resp_data_offset,
  output reg  [15:0] resp_est_time,
  output reg  [7:0]  resp_msg_count,
  output reg         resp_from_queue,
  output reg         cmd_dropped
);
  reg              ovf_active_q;
  reg  [15:0]      ovf_pid_q;
  reg  [15:0]      ovf_offset_q;
  reg  [7:0]       msg_count_q;
  reg  [1:0]       wr_ptr_q;
  reg  [1:0]       rd_ptr_q;
  reg              q_pending_q;
  reg  [15:0]      dfr_sub_q;
  reg  [7:0]       type_d;
  reg  [7:0]       pdl_d;
  reg  [15:0]      est_d;
  reg              ovf_start;
  reg              ovf_done;

  wire [39:0]      q_rd_data;
  wire             is_disc;
  wire             is_getset;
  wire             is_get;
  wire             accept;
  wire             same_ovf;
  wire [15:0]      start_off;
  wire [15:0]      remain;
  wire             q_full;
  wire             q_empty;
  wire             q_push;
  wire             q_pop;
  wire [7:0]       rsp_class;
  wire             ovf_abort;

  assign is_disc   = (cmd_class == `CC_DISC);
  assign is_get    = (cmd_class == `CC_GET);
  assign is_getset = is_get || (cmd_class == `CC_SET);
  // silent drop on checksum error or broadcast get/set
  assign accept    = cmd_valid && cmd_checksum_ok
                     && !(is_getset && cmd_broadcast);
  assign same_ovf  = ovf_active_q && is_get && (cmd_pid == ovf_pid_q);
  // a different pid or a fresh start begins at block zero
  assign start_off = same_ovf ? ovf_offset_q : 16'h0000;
  assign remain    = data_total_len - start_off;
  assign q_full    = (wr_ptr_q + 2'h1) == rd_ptr_q;
  assign q_empty   = (wr_ptr_q == rd_ptr_q);
  // a ready reply that arrives while the queue is full is not stored
  assign q_push    = deferred_ready && !q_full;
  assign q_pop     = accept && is_get && (cmd_pid == `PID_QUEUED) && !q_empty
                     && !q_pending_q;
  assign rsp_class = cmd_class + 8'h01;
  // any accepted command for another pid abandons a partial transfer
  assign ovf_abort = ovf_active_q && (cmd_pid != ovf_pid_q);

  queue_mem u_queue (
    .ref_clk (ref_clk),
    .wr_en   (q_push),
    .wr_addr (wr_ptr_q),
    .wr_data ({deferred_class, deferred_pid, dfr_sub_q}),
    .rd_addr (rd_ptr_q),
    .rd_data (q_rd_data)
  );

  // fixed priority: discovery ack, nack, timer, overflow, plain ack
  always @* begin
    type_d    = `RT_ACK;
    pdl_d     = 8'h00;
    est_d     = 16'h0000;
    ovf_start = 1'b0;
    ovf_done  = 1'b0;

    // discovery and unknown classes never see overflow, timer or nack
    if (is_disc || !is_getset) begin
      type_d = `RT_ACK;
    end else if (nack_req) begin
      type_d = `RT_NACK_REASON;
      pdl_d  = `TIMER_PDL;
    end else if (data_late) begin
      type_d = `RT_ACK_TIMER;
      pdl_d  = `TIMER_PDL;
      est_d  = est_time_100ms;
    end else if (is_get && remain > {8'h00, `MAX_PDL}) begin
      type_d    = `RT_ACK_OVERFLOW;
      pdl_d     = `MAX_PDL;
      ovf_start = 1'b1;
    end else begin
      type_d   = `RT_ACK;
      // remainder fits one block here, so its low byte is the whole length
      pdl_d    = is_get ? remain[7:0] : 8'h00;
      ovf_done = same_ovf;
    end
  end

  // one overflow transfer at a time: its pid and next block offset
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_active_q <= 1'b0;
      ovf_pid_q    <= 16'h0000;
      ovf_offset_q <= 16'h0000;
    end else if (accept) begin
      if (ovf_start) begin
        // a start outranks an abort in the same cycle
        // remaining blocks wait for explicit gets, never queued
        ovf_active_q <= 1'b1;
        ovf_pid_q    <= cmd_pid;
        ovf_offset_q <= start_off + {8'h00, `MAX_PDL};
      end else if (ovf_abort || ovf_done) begin
        ovf_active_q <= 1'b0;
        ovf_offset_q <= 16'h0000;
      end
    end
  end

  // deferred reply queue: pointers and message count
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q    <= 2'h0;
      rd_ptr_q    <= 2'h0;
      msg_count_q <= 8'h00;
      q_pending_q <= 1'b0;
    end else begin
      q_pending_q <= q_pop;
      if (q_push) begin
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      // pointer moves only once the registered read has been used
      if (q_pending_q) begin
        rd_ptr_q <= rd_ptr_q + 2'h1;
      end

      // count rises when queued, falls when fetched; net zero if both
      if (q_push && !q_pop) begin
        msg_count_q <= msg_count_q + 8'h01;
      end else if (q_pop && !q_push) begin
        msg_count_q <= msg_count_q - 8'h01;
      end
    end
  end

  // response registers; a queued reply leaves one cycle late
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dfr_sub_q        <= 16'h0000;
      resp_valid       <= 1'b0;
      resp_type        <= 8'h00;
      resp_class       <= 8'h00;
      resp_pid         <= 16'h0000;
      resp_sub_device  <= 16'h0000;
      resp_pdl         <= 8'h00;
      resp_data_offset <= 16'h0000;
      resp_est_time    <= 16'h0000;
      resp_msg_count   <= 8'h00;
      resp_from_queue  <= 1'b0;
      cmd_dropped      <= 1'b0;
    end else begin
      resp_valid      <= 1'b0;
      resp_from_queue <= 1'b0;
      // dropped commands leave the reply fields untouched
      cmd_dropped     <= cmd_valid && !accept;

      if (q_pending_q) begin
        resp_valid       <= 1'b1;
        resp_from_queue  <= 1'b1;
        resp_type        <= `RT_ACK;
        resp_class       <= q_rd_data[39:32];
        resp_pid         <= q_rd_data[31:16];
        resp_sub_device  <= q_rd_data[15:0];
        resp_pdl         <= 8'h00;
        resp_data_offset <= 16'h0000;
        resp_est_time    <= 16'h0000;
        resp_msg_count   <= msg_count_q;
      end

      if (accept) begin
        // the queued fetch itself stays silent; its reply follows
        resp_valid       <= !q_pop;
        resp_type        <= type_d;
        resp_class       <= rsp_class;
        resp_pid         <= cmd_pid;
        resp_sub_device  <= cmd_sub_device;
        resp_pdl         <= pdl_d;
        resp_msg_count   <= msg_count_q;
        resp_data_offset <= start_off;
        resp_est_time    <= est_d;
        // only the latest timer's sub-device is kept for the queued reply
        if (type_d == `RT_ACK_TIMER) begin
          dfr_sub_q <= cmd_sub_device;
        end
      end
    end
  end
endmodule // rdm_response_type_selector
`default_nettype wire

// ===== sim/rdm_sel_chk.sv
// port assertions for the response type selector
`timescale 1ns/1ps
`default_nettype none
`include "rdm_resp_consts.vh"
module rdm_sel_chk (
  input wire logic        ref_clk, arst_n, cmd_valid, cmd_checksum_ok, cmd_broadcast,
  input wire logic        data_late, nack_req, resp_valid, resp_from_queue, cmd_dropped,
  input wire logic [7:0]  cmd_class, resp_type, resp_class, resp_pdl,
  input wire logic [15:0] cmd_pid, cmd_sub_device, est_time_100ms, resp_pid,
  input wire logic [15:0] resp_sub_device, resp_est_time
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // good unicast command, queued fetch excluded since it answers late
  wire gc = cmd_valid && cmd_checksum_ok && !cmd_broadcast && cmd_pid != `PID_QUEUED;
  disc_ack_a: assert property (
    resp_valid && resp_class == `CC_DISC_RESP |-> resp_type == `RT_ACK) else $error("disc type");
  nack_get_a: assert property (
    gc && cmd_class == `CC_GET && nack_req |=> resp_valid && resp_type == `RT_NACK_REASON)
    else $error("nack type");
  timer_pdl_a: assert property (
    resp_valid && resp_type == `RT_ACK_TIMER |-> resp_pdl == `TIMER_PDL) else $error("timer pdl");
  timer_est_a: assert property (
    gc && cmd_class == `CC_GET && data_late && !nack_req
    |=> resp_valid && resp_est_time == $past(est_time_100ms)) else $error("timer estimate");
  id_echo_a: assert property (
    gc |=> resp_pid == $past(cmd_pid) && resp_sub_device == $past(cmd_sub_device)
      && resp_class == $past(cmd_class) + 8'h01) else $error("id echo");
  ovf_block_a: assert property (
    resp_valid && resp_type == `RT_ACK_OVERFLOW |-> resp_pdl == `MAX_PDL && !resp_from_queue)
    else $error("overflow block");
  bad_sum_a: assert property (
    cmd_valid && !cmd_checksum_ok |=> cmd_dropped && !resp_valid) else $error("bad sum");
  bcast_quiet_a: assert property (
    cmd_valid && cmd_broadcast && (cmd_class == `CC_GET || cmd_class == `CC_SET)
    |=> cmd_dropped && !resp_valid ##1 !resp_valid) else $error("bcast");
  cover property (resp_valid && resp_type == `RT_ACK_TIMER);
  cover property (resp_valid && resp_type == `RT_ACK_OVERFLOW);
  cover property (resp_from_queue);
endmodule // rdm_sel_chk
bind rdm_response_type_selector rdm_sel_chk chk_u (.*);
`default_nettype wire

// ===== sim/rdm_ctrl_model.sv
// controller model issuing commands and deferred-ready pulses
`timescale 1ns/1ps
`default_nettype none
`include "rdm_resp_consts.vh"
module rdm_ctrl_model (
  input wire logic   ref_clk,
  output logic       cmd_valid, cmd_checksum_ok, cmd_broadcast, data_late, nack_req,
  output logic       deferred_ready,
  output logic [7:0] cmd_class, deferred_class,
  output logic [15:0] cmd_pid, cmd_sub_device, data_total_len, est_time_100ms, deferred_pid
);
  initial {cmd_valid, cmd_checksum_ok, cmd_broadcast, data_late, nack_req, deferred_ready,
    cmd_class, deferred_class, cmd_pid, cmd_sub_device, data_total_len, est_time_100ms,
    deferred_pid} = '0;
  // repeated gets and queued fetches are issued through this one task
  task send(input [7:0] c, input [15:0] p, l, input lt, nk, ok, bc, input [15:0] e);
    @(negedge ref_clk);
    {cmd_class, cmd_pid, data_total_len, data_late, nack_req} = {c, p, l, lt, nk};
    {cmd_checksum_ok, cmd_broadcast, est_time_100ms, cmd_sub_device} = {ok, bc, e, p ^ 16'h00FF};
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_pid = ~cmd_pid; // released id must not look valid
    if (p == `PID_QUEUED) @(negedge ref_clk); // fetch answers a cycle later
  endtask
  task dfr(input [7:0] c, input [15:0] p);
    @(negedge ref_clk);
    {deferred_class, deferred_pid, deferred_ready} = {c, p, 1'b1};
    @(negedge ref_clk);
    deferred_ready = 1'b0;
  endtask
endmodule // rdm_ctrl_model
`default_nettype wire

// ===== sim/rdm_response_type_selector_test.sv
// self-checking bench for the response type selector
`timescale 1ns/1ps
`default_nettype none
`include "rdm_resp_consts.vh"
`define CHK(n, x, y) begin comparisons++; if ((x) !== (y)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", n, x, y); end end
module rdm_response_type_selector_test;
  logic ref_clk, arst_n, cmd_valid, cmd_checksum_ok, cmd_broadcast, data_late, nack_req;
  logic deferred_ready, resp_valid, resp_from_queue, cmd_dropped;
  logic [7:0] cmd_class, deferred_class, resp_type, resp_class, resp_pdl, resp_msg_count;
  logic [15:0] cmd_pid, cmd_sub_device, data_total_len, est_time_100ms, deferred_pid;
  logic [15:0] resp_pid, resp_sub_device, resp_data_offset, resp_est_time;
  logic [40:0] q[$];
  logic [40:0] e;
  logic [31:0] rs = 32'h0B9E5F4C;
  logic [15:0] dfr_pid = 16'h0012;
  int n_mismatch = 0, comparisons = 0, i;
  rdm_response_type_selector dut_u (.*);
  rdm_ctrl_model ctl_u (.*);
  initial begin ref_clk = 0; forever #2 ref_clk = ~ref_clk; end
  function logic [31:0] rnd(); rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5; return rs; endfunction
  // note bit 40 skips pdl and offset, count FF marks a queued reply
  task go(input [7:0] c, input [15:0] p, l, input lt, nk, input [40:0] x);
    logic [31:0] r;
    r = rnd();
    q.push_back(x);
    ctl_u.send(c, p, l, lt, nk, 1'b1, 1'b0, r[15:0]);
  endtask
  // outputs are read at the falling edge, half a cycle after launch
  always @(negedge ref_clk) if (resp_valid) begin
    if (q.size() == 0) `CHK("reply", 1'b0, 1'b1)
    else begin
      e = q.pop_front();
      `CHK("type", e[39:32], resp_type)
      if (!e[40]) `CHK("pdl_off", e[31:8], {resp_pdl, resp_data_offset})
      if (e[7:0] != 8'hFF) `CHK("count", e[7:0], resp_msg_count)
      `CHK("from_q", e[7:0] == 8'hFF, resp_from_queue)
      if (resp_from_queue) `CHK("q_ids", {`CC_GET_RESP, dfr_pid}, {resp_class, resp_pid})
    end
  end
  task results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    arst_n = 0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) arst_n = 1;
    go(`CC_GET, 16'h0010, 16'h01F4, 0, 0, {9'h003, 8'hE7, 16'h0000, 8'h00});
    go(`CC_GET, 16'h0010, 16'h01F4, 0, 0, {9'h003, 8'hE7, 16'h00E7, 8'h00});
    go(`CC_GET, 16'h0010, 16'h01F4, 0, 0, {9'h000, 8'h26, 16'h01CE, 8'h00});
    go(`CC_GET, 16'h0010, 16'h01F4, 0, 0, {9'h003, 8'hE7, 16'h0000, 8'h00});
    go(`CC_GET, 16'h0011, 16'h000A, 0, 0, {9'h000, 8'h0A, 16'h0000, 8'h00});
    go(`CC_GET, 16'h0010, 16'h01F4, 0, 0, {9'h003, 8'hE7, 16'h0000, 8'h00});
    go(`CC_DISC, 16'h0001, 16'h0004, 1, 1, {9'h100, 24'h0, 8'h00});
    for (i = 0; i < 4; i++) go(i[0] ? `CC_SET : `CC_GET, {1'b1, rs[14:0]}, 16'h0004, 0, 1,
      {9'h102, 24'h0, 8'h00});
    go(`CC_SET, 16'h0012, 16'h0004, 1, 0, {9'h101, 24'h0, 8'h00});
    go(`CC_GET, 16'h0012, 16'h0004, 1, 0, {9'h101, 24'h0, 8'h00});
    ctl_u.send(`CC_GET, 16'h0013, 16'h0004, 0, 0, 1'b0, 1'b0, 16'h0000);
    ctl_u.send(`CC_SET, 16'h0013, 16'h0004, 0, 0, 1'b1, 1'b1, 16'h0000);
    ctl_u.dfr(`CC_GET_RESP, dfr_pid);
    go(`CC_GET, 16'h0014, 16'h0004, 0, 0, {9'h000, 8'h04, 16'h0000, 8'h01});
    go(`CC_GET, `PID_QUEUED, 16'h0000, 0, 0, {9'h100, 24'h0, 8'hFF});
    for (i = 0; i < 20 && q.size() > 0; i++) @(posedge ref_clk);
    if (q.size() > 0) `CHK("drain", 1'b0, 1'b1)
    results();
  end
endmodule // rdm_response_type_selector_test
`default_nettype wire
